// ===== pmr_fault_pgood_regs.sv
// Fault shutdown mask and first power-good output tree mask registers
`timescale 1ns/1ps
module pmr_fault_pgood_regs (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [pmr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic                       reg_wr_en_i,
    input  wire logic [pmr_pkg::DATA_W-1:0] reg_wr_data_i,
    input  wire logic                       reg_rd_en_i,
    output logic      [pmr_pkg::DATA_W-1:0] reg_rd_data_o,
    input  wire logic [5:0]                 stepdown_pg_i,
    input  wire logic                       aux_ldo_two_pg_i,
    input  wire logic                       load_switch_a_pg_i,
    input  wire logic                       termination_ldo_pg_i,
    input  wire logic                       load_switch_b_one_pg_i,
    input  wire logic                       load_switch_b_two_pg_i,
    input  wire logic                       aux_ldo_three_pg_i,
    input  wire logic [pmr_pkg::CTL_N-1:0]  control_input_pin_i,
    input  wire logic                       aux_ldo_one_fault_i,
    input  wire logic                       termination_ldo_fault_i,
    input  wire logic                       load_switch_b_two_fault_i,
    input  wire logic                       load_switch_b_one_fault_i,
    input  wire logic                       aux_ldo_three_fault_i,
    output logic                            pgood_output_one_o,
    output logic                            shutdown_request_o
);
    logic [pmr_pkg::FAULT_W-1:0]  fault_shutdown_mask_upper;
    logic [pmr_pkg::DATA_W-1:0]   pgood_tree_mask_rails;
    logic [pmr_pkg::DATA_W-1:0]   pgood_tree_mask_aux;
    logic [pmr_pkg::CTL_N-1:0]    ctl_sync1;
    logic [pmr_pkg::CTL_N-1:0]    ctl_sync2;
    logic [pmr_pkg::CTL_N-1:0]    ctl_sync3;
    logic [pmr_pkg::CTL_N-1:0]    ctl_state;
    logic [pmr_pkg::FAULT_W-1:0]  fault_vec;
    logic [pmr_pkg::DATA_W-1:0]   rail_good;
    logic [pmr_pkg::DATA_W-1:0]   aux_good;
    logic [pmr_pkg::DATA_W-1:0]   next_rd_data;
    logic                         next_pgood;
    logic                         next_shutdown;

    // Register writes; reserved upper bits of the fault mask are not stored, they read constant
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_shutdown_mask_upper <= pmr_pkg::RST_FAULT_MASK_UPPER[pmr_pkg::FAULT_W-1:0];
        end else if (reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_FAULT_MASK_UPPER) begin
            fault_shutdown_mask_upper <= reg_wr_data_i[pmr_pkg::FAULT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pgood_tree_mask_rails <= pmr_pkg::RST_TREE_MASK_RAILS;
        end else if (reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_RAILS) begin
            pgood_tree_mask_rails <= reg_wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pgood_tree_mask_aux <= pmr_pkg::RST_TREE_MASK_AUX;
        end else if (reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_AUX) begin
            pgood_tree_mask_aux <= reg_wr_data_i;
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always_comb begin
        case (reg_addr_i)
            pmr_pkg::OFF_FAULT_MASK_UPPER: begin
                next_rd_data = {pmr_pkg::RST_FAULT_MASK_UPPER[7:5],
                                fault_shutdown_mask_upper};
            end
            pmr_pkg::OFF_TREE_MASK_RAILS: begin
                next_rd_data = pgood_tree_mask_rails;
            end
            pmr_pkg::OFF_TREE_MASK_AUX: begin
                next_rd_data = pgood_tree_mask_aux;
            end
            default: begin
                next_rd_data = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rd_data_o <= 8'h00;
        end else if (reg_rd_en_i) begin
            reg_rd_data_o <= next_rd_data;
        end
    end

    // Control pins are asynchronous; a level is accepted once stages two and three agree
    generate
        for (genvar i = 0; i < pmr_pkg::CTL_N; i++) begin : g_ctl_sync
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    ctl_sync1[i] <= pmr_pkg::CTL_RST[i];
                    ctl_sync2[i] <= pmr_pkg::CTL_RST[i];
                    ctl_sync3[i] <= pmr_pkg::CTL_RST[i];
                    ctl_state[i] <= pmr_pkg::CTL_RST[i];
                end else begin
                    ctl_sync1[i] <= control_input_pin_i[i];
                    ctl_sync2[i] <= ctl_sync1[i];
                    ctl_sync3[i] <= ctl_sync2[i];
                    if (ctl_sync2[i] == ctl_sync3[i]) begin
                        ctl_state[i] <= ctl_sync3[i];
                    end
                end
            end
        end
    endgenerate

    // Power-good tree: a masked source counts as good
    always_comb begin
        rail_good = {aux_ldo_two_pg_i, load_switch_a_pg_i, stepdown_pg_i};
        aux_good  = {ctl_state[3], ctl_state[2], ctl_state[1], ctl_state[0],
                     termination_ldo_pg_i, load_switch_b_two_pg_i,
                     load_switch_b_one_pg_i, aux_ldo_three_pg_i};
        next_pgood = &(rail_good | pgood_tree_mask_rails) &
                     &(aux_good | pgood_tree_mask_aux);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pgood_output_one_o <= 1'b0;
        end else begin
            pgood_output_one_o <= next_pgood;
        end
    end

    // Fault gating toward the shutdown sequencer
    always_comb begin
        fault_vec = {aux_ldo_one_fault_i, termination_ldo_fault_i,
                     load_switch_b_two_fault_i, load_switch_b_one_fault_i,
                     aux_ldo_three_fault_i};
        next_shutdown = |(fault_vec & ~fault_shutdown_mask_upper);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shutdown_request_o <= 1'b0;
        end else begin
            shutdown_request_o <= next_shutdown;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wr_upper;
        reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_FAULT_MASK_UPPER;
    endsequence

    sequence s_rd_upper;
        reg_rd_en_i && reg_addr_i == pmr_pkg::OFF_FAULT_MASK_UPPER;
    endsequence

    sequence s_pin_steady;
        (rst_n_i && $stable(control_input_pin_i))[*4];
    endsequence

    property p_reset_values;
        @(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> fault_shutdown_mask_upper == 5'h1F && pgood_tree_mask_rails == 8'hC2
                     && pgood_tree_mask_aux == 8'hAF;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_upper_write;
        s_wr_upper |=> fault_shutdown_mask_upper == $past(reg_wr_data_i[4:0]);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("fault mask write lost");

    property p_reserved_const;
        s_rd_upper |=> reg_rd_data_o[7:5] == pmr_pkg::RST_FAULT_MASK_UPPER[7:5]
                       && reg_rd_data_o[4:0] == $past(fault_shutdown_mask_upper);
    endproperty
    a_reserved_const: assert property (p_reserved_const) else $error("reserved bits wrong");

    property p_rails_write;
        reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_RAILS
            ##1 reg_rd_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_RAILS
            |=> reg_rd_data_o == $past(reg_wr_data_i, 2);
    endproperty
    a_rails_write: assert property (p_rails_write) else $error("rail mask readback");

    property p_aux_write;
        reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_AUX
            |=> pgood_tree_mask_aux == $past(reg_wr_data_i);
    endproperty
    a_aux_write: assert property (p_aux_write) else $error("aux mask write lost");

    property p_unmapped_zero;
        reg_rd_en_i && reg_addr_i != pmr_pkg::OFF_FAULT_MASK_UPPER
            && reg_addr_i != pmr_pkg::OFF_TREE_MASK_RAILS
            && reg_addr_i != pmr_pkg::OFF_TREE_MASK_AUX |=> reg_rd_data_o == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

    property p_fault_shutdown;
        (fault_vec & ~fault_shutdown_mask_upper) != 5'h00 |=> shutdown_request_o;
    endproperty
    a_fault_shutdown: assert property (p_fault_shutdown) else $error("fault missed");

    property p_masked_no_shutdown;
        (fault_vec & ~fault_shutdown_mask_upper) == 5'h00 |=> !shutdown_request_o;
    endproperty
    a_masked_no_shutdown: assert property (p_masked_no_shutdown) else $error("masked fault");

    property p_pgood_low;
        !stepdown_pg_i[0] && !pgood_tree_mask_rails[0] |=> !pgood_output_one_o;
    endproperty
    a_pgood_low: assert property (p_pgood_low) else $error("unmasked bad rail passed");

    property p_pin_follow;
        s_pin_steady |=> ctl_state == $past(control_input_pin_i, 3);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin state not taken");

    property p_rd_hold;
        !reg_rd_en_i |=> $stable(reg_rd_data_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

    property p_rails_store;
        reg_wr_en_i && reg_addr_i == pmr_pkg::OFF_TREE_MASK_RAILS
            |=> pgood_tree_mask_rails == $past(reg_wr_data_i);
    endproperty
    a_rails_store: assert property (p_rails_store) else $error("rail mask write lost");

    property p_reset_outputs;
        disable iff (1'b0)
        !rst_n_i |=> !pgood_output_one_o && !shutdown_request_o && reg_rd_data_o == 8'h00;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared");

    property p_all_masked_good;
        &pgood_tree_mask_rails && &pgood_tree_mask_aux |=> pgood_output_one_o;
    endproperty
    a_all_masked_good: assert property (p_all_masked_good) else $error("masked tree bad");

    property p_ldo_two_bad;
        !aux_ldo_two_pg_i && !pgood_tree_mask_rails[pmr_pkg::RAIL_AUX_LDO_TWO]
            |=> !pgood_output_one_o;
    endproperty
    a_ldo_two_bad: assert property (p_ldo_two_bad) else $error("ldo two passed");

    property p_switch_a_bad;
        !load_switch_a_pg_i && !pgood_tree_mask_rails[pmr_pkg::RAIL_SWITCH_A]
            |=> !pgood_output_one_o;
    endproperty
    a_switch_a_bad: assert property (p_switch_a_bad) else $error("switch a passed");

    property p_stepdown_six_bad;
        !stepdown_pg_i[pmr_pkg::STEPDOWN_N-1] && !pgood_tree_mask_rails[pmr_pkg::STEPDOWN_N-1]
            |=> !pgood_output_one_o;
    endproperty
    a_stepdown_six_bad: assert property (p_stepdown_six_bad) else $error("rail six passed");

    property p_pin_five_bad;
        !ctl_state[3] && !pgood_tree_mask_aux[pmr_pkg::AUX_CTL_FIVE]
            |=> !pgood_output_one_o;
    endproperty
    a_pin_five_bad: assert property (p_pin_five_bad) else $error("pin five passed");

    property p_pin_one_bad;
        !ctl_state[0] && !pgood_tree_mask_aux[pmr_pkg::AUX_CTL_ONE]
            |=> !pgood_output_one_o;
    endproperty
    a_pin_one_bad: assert property (p_pin_one_bad) else $error("pin one passed");

    property p_term_bad;
        !termination_ldo_pg_i && !pgood_tree_mask_aux[pmr_pkg::AUX_TERMINATION]
            |=> !pgood_output_one_o;
    endproperty
    a_term_bad: assert property (p_term_bad) else $error("termination passed");

    property p_switch_b_two_bad;
        !load_switch_b_two_pg_i && !pgood_tree_mask_aux[pmr_pkg::AUX_SWITCH_B_TWO]
            |=> !pgood_output_one_o;
    endproperty
    a_switch_b_two_bad: assert property (p_switch_b_two_bad) else $error("switch b two passed");

    property p_switch_b_one_bad;
        !load_switch_b_one_pg_i && !pgood_tree_mask_aux[pmr_pkg::AUX_SWITCH_B_ONE]
            |=> !pgood_output_one_o;
    endproperty
    a_switch_b_one_bad: assert property (p_switch_b_one_bad) else $error("switch b one passed");

    property p_ldo_three_bad;
        !aux_ldo_three_pg_i && !pgood_tree_mask_aux[pmr_pkg::AUX_AUX_LDO_THREE]
            |=> !pgood_output_one_o;
    endproperty
    a_ldo_three_bad: assert property (p_ldo_three_bad) else $error("ldo three passed");
endmodule : pmr_fault_pgood_regs

// ===== pmr_pkg.sv
// Register map, reset values and field positions for the fault and power-good mask bank
package pmr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] OFF_FAULT_MASK_UPPER = 8'hA3;
    localparam logic [7:0] OFF_TREE_MASK_RAILS  = 8'hA4;
    localparam logic [7:0] OFF_TREE_MASK_AUX    = 8'hA5;

    localparam logic [7:0] RST_FAULT_MASK_UPPER = 8'h3F;
    localparam logic [7:0] RST_TREE_MASK_RAILS  = 8'hC2;
    localparam logic [7:0] RST_TREE_MASK_AUX    = 8'hAF;

    // Fault mask: writable field is bits 4..0, bits 7..5 read fixed at their reset value
    localparam int unsigned FAULT_W            = 5;
    localparam int unsigned FLT_AUX_LDO_THREE  = 0;
    localparam int unsigned FLT_SWITCH_B_ONE   = 1;
    localparam int unsigned FLT_SWITCH_B_TWO   = 2;
    localparam int unsigned FLT_TERMINATION    = 3;
    localparam int unsigned FLT_AUX_LDO_ONE    = 4;

    // Rail tree mask
    localparam int unsigned STEPDOWN_N         = 6;
    localparam int unsigned RAIL_SWITCH_A      = 6;
    localparam int unsigned RAIL_AUX_LDO_TWO   = 7;

    // Aux tree mask
    localparam int unsigned AUX_AUX_LDO_THREE  = 0;
    localparam int unsigned AUX_SWITCH_B_ONE   = 1;
    localparam int unsigned AUX_SWITCH_B_TWO   = 2;
    localparam int unsigned AUX_TERMINATION    = 3;
    localparam int unsigned AUX_CTL_ONE        = 4;
    localparam int unsigned AUX_CTL_TWO        = 5;
    localparam int unsigned AUX_CTL_FOUR       = 6;
    localparam int unsigned AUX_CTL_FIVE       = 7;

    // Control pins in port order: one, two, four, five
    localparam int unsigned CTL_N              = 4;
    localparam logic [3:0]  CTL_RST            = 4'h0;
endpackage : pmr_pkg

// ===== pmr_src_model.sv
// Behavioural model of the supervised rails, pins and fault sources
`timescale 1ns/1ps
module pmr_src_model (
    input  wire logic        clk_i,
    input  wire logic [20:0] state_i,
    output logic      [5:0]  stepdown_pg_o,
    output logic      [5:0]  misc_pg_o,
    output logic      [3:0]  pin_o,
    output logic      [4:0]  fault_o
);
    // Sources move only after a clock edge, as real supervisors do
    always_ff @(posedge clk_i) begin
        stepdown_pg_o <= state_i[5:0];
        misc_pg_o     <= state_i[11:6];
        pin_o         <= state_i[15:12];
        fault_o       <= state_i[20:16];
    end
endmodule : pmr_src_model

// ===== pmr_fault_pgood_regs_tb_top.sv
// Self-checking bench for the fault and power-good mask registers
`timescale 1ns/1ps
module pmr_fault_pgood_regs_tb_top;
    localparam logic [20:0] ALL_GOOD = 21'h00_FFFF;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [20:0] src = 21'h00_FFFF;
    logic [7:0]  rdata;
    logic [5:0]  sd_pg;
    logic [5:0]  misc;
    logic [3:0]  pins;
    logic [4:0]  flt;
    logic        pgood;
    logic        sdown;
    logic [7:0]  d;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          seed = 32'h60da;

    pmr_src_model src_u (.clk_i(clk_i), .state_i(src), .stepdown_pg_o(sd_pg),
        .misc_pg_o(misc), .pin_o(pins), .fault_o(flt));

    pmr_fault_pgood_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wr_en_i(wr_en), .reg_wr_data_i(wdata),
        .reg_rd_en_i(rd_en), .reg_rd_data_o(rdata), .stepdown_pg_i(sd_pg),
        .load_switch_a_pg_i(misc[0]), .aux_ldo_two_pg_i(misc[1]),
        .termination_ldo_pg_i(misc[2]), .load_switch_b_one_pg_i(misc[3]),
        .load_switch_b_two_pg_i(misc[4]), .aux_ldo_three_pg_i(misc[5]),
        .control_input_pin_i(pins), .aux_ldo_three_fault_i(flt[0]),
        .load_switch_b_one_fault_i(flt[1]), .load_switch_b_two_fault_i(flt[2]),
        .termination_ldo_fault_i(flt[3]), .aux_ldo_one_fault_i(flt[4]),
        .pgood_output_one_o(pgood), .shutdown_request_o(sdown));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Masked sources count as good
    function automatic logic exp_pg(logic [7:0] a4, logic [7:0] a5, logic [20:0] s);
        return (&(s[7:0] | a4)) & (&({s[15:12], s[8], s[10], s[9], s[11]} | a5));
    endfunction : exp_pg

    function automatic logic exp_sd(logic [7:0] a3, logic [20:0] s);
        return |(s[20:16] & ~a3[4:0]);
    endfunction : exp_sd

    task automatic give_verdict;
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_i);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_i);
        wr_en <= 1'b0;
    endtask : wr

    // Write then read the same offset on the next edge
    task automatic wr_rd(logic [7:0] a, logic [7:0] v, output logic [7:0] q);
        @(posedge clk_i);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_i);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk_i);
        rd_en <= 1'b0;
        #1;
        q = rdata;
    endtask : wr_rd

    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_i);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic chk_rst;
        rd(pmr_pkg::OFF_FAULT_MASK_UPPER, d);
        check("a3 reset", d, pmr_pkg::RST_FAULT_MASK_UPPER);
        rd(pmr_pkg::OFF_TREE_MASK_RAILS, d);
        check("a4 reset", d, pmr_pkg::RST_TREE_MASK_RAILS);
        rd(pmr_pkg::OFF_TREE_MASK_AUX, d);
        check("a5 reset", d, pmr_pkg::RST_TREE_MASK_AUX);
        rd(8'hA2, d);
        check("unmapped", d, 8'h00);
    endtask : chk_rst

    // Pin sync needs several cycles, so settle before judging outputs
    task automatic apply(logic [7:0] a3, logic [7:0] a4, logic [7:0] a5, logic [20:0] s);
        wr(pmr_pkg::OFF_FAULT_MASK_UPPER, a3);
        wr_rd(pmr_pkg::OFF_TREE_MASK_RAILS, a4, d);
        check("a4 back to back", d, a4);
        wr(pmr_pkg::OFF_TREE_MASK_AUX, a5);
        @(posedge clk_i);
        src <= s;
        repeat (8) @(posedge clk_i);
        #1;
        check("pgood", {7'h00, pgood}, {7'h00, exp_pg(a4, a5, s)});
        check("shutdown", {7'h00, sdown}, {7'h00, exp_sd(a3, s)});
        rd(pmr_pkg::OFF_FAULT_MASK_UPPER, d);
        check("a3", d, {pmr_pkg::RST_FAULT_MASK_UPPER[7:5], a3[4:0]});
        rd(pmr_pkg::OFF_TREE_MASK_RAILS, d);
        check("a4", d, a4);
        rd(pmr_pkg::OFF_TREE_MASK_AUX, d);
        check("a5", d, a5);
    endtask : apply

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk_rst();
        wr(8'hA6, 8'h55);
        chk_rst();
        // One source failing at a time, all open then all masked
        for (int k = 0; k < 21; k++) begin
            apply(8'h00, 8'h00, 8'h00, ALL_GOOD ^ (21'h1 << k));
            apply(8'hFF, 8'hFF, 8'hFF, ALL_GOOD ^ (21'h1 << k));
        end
        for (int n = 0; n < 40; n++) begin
            apply(8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                  ALL_GOOD ^ 21'($random(seed) & $random(seed) & $random(seed)));
        end
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("pgood in reset", {7'h00, pgood}, 8'h00);
        check("shutdown in reset", {7'h00, sdown}, 8'h00);
        chk_rst();
        give_verdict();
    end
endmodule : pmr_fault_pgood_regs_tb_top
